// ### core/rrx_consts.vh
// constants for the return and rotate execution block
`ifndef RRX_CONSTS_VH
`define RRX_CONSTS_VH
`define RRX_OP_RESET 14'h0001
`define RRX_OP_RETURN 14'h0008
`define RRX_OP_RETURN_FROM_INTERRUPT 14'h0009
`define RRX_OP_FULL_MASK 14'h3fff
`define RRX_RETURN_WITH_LITERAL_MASK 14'h3f00
`define RRX_RETURN_WITH_LITERAL_CODE 14'h3400
`define RRX_ROTATE_LEFT_CARRY_MASK 14'h3f00
`define RRX_ROTATE_LEFT_CARRY_CODE 14'h0d00
`define RRX_ROTATE_LEFT_CARRY_DEST_BIT 7
`define RRX_ADDR_W 4'h0
`define RRX_ADDR_STATUS 4'h1
`define RRX_ADDR_INTCTL 4'h2
`define RRX_ADDR_PWRCTL 4'h3
`define RRX_ADDR_PC 4'h4
`define RRX_ADDR_EXEC 4'h5
`define RRX_GLOBAL_IRQ_ENABLE_BIT 7
`define RRX_SOFTWARE_RESET_FLAG_BIT 2
`define RRX_CARRY_BIT 0
`define RRX_W_RESET 8'h00
`define RRX_PC_RESET 15'h0000
`define RRX_SOFTWARE_RESET_FLAG_RESET 1'h1
`define RRX_RET_CYCLES 2
`endif

// ### core/rrx_rotate.v
// rotate left through carry, result and carry out only
`timescale 1ns/1ps
`default_nettype none
module rrx_rotate (
    input wire [7:0] i_operand,
    input wire i_carry,
    output wire [7:0] o_result,
    output wire o_carry
);
    assign o_result = {i_operand[6:0], i_carry};
    assign o_carry = i_operand[7];
endmodule // rrx_rotate
`default_nettype wire

// ### core/rrx_exec.v
// execution unit for software reset, returns and rotate left
`timescale 1ns/1ps
`default_nettype none
`include "rrx_consts.vh"
module rrx_exec (
    input wire i_clk,
    input wire i_resetn,
    input wire i_instr_valid,
    input wire [13:0] i_instr,
    input wire [14:0] i_stack_top,
    input wire [7:0] i_file_data,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    output reg o_soft_reset,
    output reg o_stack_pop,
    output reg o_pc_load,
    output reg [14:0] o_pc_value,
    output reg o_file_we,
    output reg [6:0] o_file_addr,
    output reg [7:0] o_file_wdata,
    output reg [7:0] o_w,
    output reg o_carry,
    output reg o_global_irq_enable,
    output reg o_busy
);
    localparam [1:0] S_RUN = 2'h1;
    localparam [1:0] S_RET = 2'h2;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg software_reset_flag_reg;
    wire take;
    wire is_reset;
    wire is_return;
    wire is_return_from_interrupt;
    wire is_return_with_literal;
    wire is_rotate_left_carry;
    wire is_ret;
    wire rot_to_file;
    wire rot_to_w;
    wire [7:0] rot_result;
    wire rot_carry;
    wire wr_w;
    wire wr_status;
    wire wr_intctl;
    wire wr_pwrctl;

    // opcode match under a mask
    function match;
        input [13:0] instr;
        input [13:0] mask;
        input [13:0] code;
        begin
            match = ((instr & mask) == code);
        end
    endfunction

    // bus write strobe aimed at one register address
    function wr_hit;
        input wr;
        input [3:0] addr;
        input [3:0] target;
        begin
            wr_hit = wr & (addr == target);
        end
    endfunction

    assign take = i_instr_valid & state_reg[0];
    assign is_reset = take & match(i_instr, `RRX_OP_FULL_MASK,
        `RRX_OP_RESET);
    assign is_return = take & match(i_instr, `RRX_OP_FULL_MASK,
        `RRX_OP_RETURN);
    assign is_return_from_interrupt = take & match(i_instr,
        `RRX_OP_FULL_MASK, `RRX_OP_RETURN_FROM_INTERRUPT);
    assign is_return_with_literal = take & match(i_instr,
        `RRX_RETURN_WITH_LITERAL_MASK, `RRX_RETURN_WITH_LITERAL_CODE);
    assign is_rotate_left_carry = take & match(i_instr,
        `RRX_ROTATE_LEFT_CARRY_MASK, `RRX_ROTATE_LEFT_CARRY_CODE);
    assign is_ret = is_return | is_return_from_interrupt |
        is_return_with_literal;
    assign rot_to_file = is_rotate_left_carry &
        i_instr[`RRX_ROTATE_LEFT_CARRY_DEST_BIT];
    assign rot_to_w = is_rotate_left_carry &
        ~i_instr[`RRX_ROTATE_LEFT_CARRY_DEST_BIT];
    assign wr_w = wr_hit(i_wr, i_addr, `RRX_ADDR_W);
    assign wr_status = wr_hit(i_wr, i_addr, `RRX_ADDR_STATUS);
    assign wr_intctl = wr_hit(i_wr, i_addr, `RRX_ADDR_INTCTL);
    assign wr_pwrctl = wr_hit(i_wr, i_addr, `RRX_ADDR_PWRCTL);

    rrx_rotate u_rotate (
        .i_operand(i_file_data),
        .i_carry(o_carry),
        .o_result(rot_result),
        .o_carry(rot_carry)
    );

    // two-cycle return sequencing
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_RUN: begin
                if (is_ret) begin
                    state_next = S_RET;
                end
            end
            S_RET: begin
                state_next = S_RUN;
            end
            default: begin
                state_next = S_RUN;
            end
        endcase
    end

    // state and busy flag
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            state_reg <= S_RUN;
            o_busy <= 1'h0;
        end else begin
            state_reg <= state_next;
            o_busy <= state_next[1];
        end
    end

    // one-cycle request pulses
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_soft_reset <= 1'h0;
            o_stack_pop <= 1'h0;
            o_pc_load <= 1'h0;
            o_file_we <= 1'h0;
        end else begin
            o_soft_reset <= is_reset;
            o_stack_pop <= is_ret;
            o_pc_load <= is_ret;
            o_file_we <= rot_to_file;
        end
    end

    // new program counter, held between returns
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pc_value <= `RRX_PC_RESET;
        end else if (is_ret) begin
            o_pc_value <= i_stack_top;
        end
    end

    // file write address and data, held between rotates
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_file_addr <= 7'h00;
            o_file_wdata <= 8'h00;
        end else if (is_rotate_left_carry) begin
            o_file_addr <= i_instr[6:0];
            o_file_wdata <= rot_result;
        end
    end

    // working register, instruction writes win over the bus
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_w <= `RRX_W_RESET;
        end else if (is_return_with_literal) begin
            o_w <= i_instr[7:0];
        end else if (rot_to_w) begin
            o_w <= rot_result;
        end else if (wr_w) begin
            o_w <= i_wdata;
        end
    end

    // carry flag, the rotate wins over a bus write
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_carry <= 1'h0;
        end else if (is_rotate_left_carry) begin
            o_carry <= rot_carry;
        end else if (wr_status) begin
            o_carry <= i_wdata[`RRX_CARRY_BIT];
        end
    end

    // global interrupt enable, the return from interrupt sets it over a bus write
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_global_irq_enable <= 1'h0;
        end else if (is_return_from_interrupt) begin
            o_global_irq_enable <= 1'h1;
        end else if (wr_intctl) begin
            o_global_irq_enable <= i_wdata[`RRX_GLOBAL_IRQ_ENABLE_BIT];
        end
    end

    // software reset flag, the clear wins over a bus write
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            software_reset_flag_reg <= `RRX_SOFTWARE_RESET_FLAG_RESET;
        end else if (is_reset) begin
            software_reset_flag_reg <= 1'h0;
        end else if (wr_pwrctl) begin
            software_reset_flag_reg <=
                i_wdata[`RRX_SOFTWARE_RESET_FLAG_BIT];
        end
    end

    // register read port, data one cycle after the strobe
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (i_addr == `RRX_ADDR_W) begin
                o_rdata <= o_w;
            end else if (i_addr == `RRX_ADDR_STATUS) begin
                o_rdata <= {7'h00, o_carry};
            end else if (i_addr == `RRX_ADDR_INTCTL) begin
                o_rdata <= {o_global_irq_enable, 7'h00};
            end else if (i_addr == `RRX_ADDR_PWRCTL) begin
                o_rdata <= {5'h00, software_reset_flag_reg, 2'h0};
            end else if (i_addr == `RRX_ADDR_PC) begin
                o_rdata <= o_pc_value[7:0];
            end else if (i_addr == `RRX_ADDR_EXEC) begin
                o_rdata <= {7'h00, o_busy};
            end else begin
                o_rdata <= 8'h00;
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule // rrx_exec
`default_nettype wire

// ### sim/rrx_exec_asserts.sv
// assertions for the return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
module rrx_exec_asserts (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_instr_valid,
    input wire logic [13:0] i_instr,
    input wire logic [14:0] i_stack_top,
    input wire logic [7:0] i_file_data,
    input wire logic o_soft_reset,
    input wire logic o_stack_pop,
    input wire logic o_pc_load,
    input wire logic [14:0] o_pc_value,
    input wire logic o_file_we,
    input wire logic [7:0] o_w,
    input wire logic o_carry,
    input wire logic o_global_irq_enable,
    input wire logic o_busy
);
    wire logic take = i_instr_valid && !o_busy;
    wire logic ret = i_instr == 14'h0008 || i_instr == 14'h0009
        || i_instr[13:8] == 6'h34;
    wire logic rot = i_instr[13:8] == 6'h0d;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_reset_pulse: assert property (
        take && i_instr == 14'h0001 |=> o_soft_reset)
        else $error("no reset pulse");
    chk_pop_load: assert property (
        take && ret |=> o_stack_pop && o_pc_load
        && o_pc_value == $past(i_stack_top)) else $error("bad pop");
    chk_irq_enable_set: assert property (
        take && i_instr == 14'h0009 |=> o_global_irq_enable)
        else $error("enable not set");
    chk_two_cycle: assert property (
        take && ret |=> o_busy ##1 !o_busy) else $error("bad busy");
    chk_flags_kept: assert property (
        take && ret |=> $stable(o_carry)) else $error("flag changed");
    chk_lit_to_w: assert property (
        take && i_instr[13:8] == 6'h34 |=> o_w == $past(i_instr[7:0]))
        else $error("bad literal");
    chk_rot_carry: assert property (
        take && rot |=> o_carry == $past(i_file_data[7]))
        else $error("bad carry");
    chk_rot_to_w: assert property (
        take && rot && !i_instr[7]
        |=> o_w == {$past(i_file_data[6:0]), $past(o_carry)})
        else $error("bad w");
    chk_rot_dest: assert property (
        take && rot |=> o_file_we == $past(i_instr[7]) && !o_busy)
        else $error("bad dest");
    chk_pop_single: assert property (
        o_stack_pop |=> !o_stack_pop) else $error("pop too long");
    chk_reset_single: assert property (
        o_soft_reset |=> !o_soft_reset) else $error("reset too long");
endmodule // rrx_exec_asserts
bind rrx_exec rrx_exec_asserts u_chk (.i_clk, .i_resetn, .i_instr_valid,
    .i_instr, .i_stack_top, .i_file_data, .o_soft_reset, .o_stack_pop,
    .o_pc_load, .o_pc_value, .o_file_we, .o_w, .o_carry,
    .o_global_irq_enable, .o_busy);
`default_nettype wire

// ### sim/tb_top.sv
// testbench for the return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk = 0, i_resetn = 0, i_instr_valid = 0, i_wr = 0, i_rd = 0;
    logic [13:0] i_instr = 0;
    logic [14:0] i_stack_top = 0;
    logic [7:0] i_file_data = 0, i_wdata = 0;
    logic [3:0] i_addr = 0;
    wire logic [7:0] o_rdata, o_file_wdata, o_w;
    wire logic [14:0] o_pc_value;
    wire logic [6:0] o_file_addr;
    wire logic o_soft_reset, o_stack_pop, o_pc_load, o_file_we;
    wire logic o_carry, o_global_irq_enable, o_busy;
    int fails = 0, checks = 0, cyc = 0;
    rrx_exec uut (.i_clk, .i_resetn, .i_instr_valid, .i_instr, .i_stack_top,
        .i_file_data, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_soft_reset,
        .o_stack_pop, .o_pc_load, .o_pc_value, .o_file_we, .o_file_addr,
        .o_file_wdata, .o_w, .o_carry, .o_global_irq_enable, .o_busy);
    initial forever #12.5 i_clk = ~i_clk;
    task tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 2000) begin
            fails++;
            tally_and_finish();
        end
    end
    task cmp(input logic [15:0] g, e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    // issue one instruction, nx is driven the next cycle, while the block is busy if the first was a return
    task iss(input logic [13:0] in, nx, input logic [14:0] st,
        input logic [7:0] fd);
        @(posedge i_clk);
        i_instr_valid <= 1;
        i_instr <= in;
        i_stack_top <= st;
        i_file_data <= fd;
        @(posedge i_clk);
        i_instr_valid <= nx != 0;
        i_instr <= nx;
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 0;
        #1 cmp(o_rdata, e);
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1;
        rd(4'h3, 8'h04);
        iss(14'h0d05, 0, 0, 8'he6);
        cmp({o_file_we, o_w}, 9'h0cc);
        cmp(o_carry, 1);
        iss(14'h0daa, 0, 0, 8'h81);
        cmp({o_file_we, o_file_addr}, 8'haa);
        cmp({o_carry, o_file_wdata}, 9'h103);
        iss(14'h34a5, 14'h0008, 15'h1234, 0);
        cmp({o_busy, o_stack_pop, o_pc_load, o_w}, 11'h7a5);
        cmp({o_carry, o_pc_value}, 16'h9234);
        @(posedge i_clk);
        i_instr_valid <= 0;
        #1 cmp({o_busy, o_stack_pop}, 0);
        iss(14'h0008, 0, 15'h7fff, 0);
        cmp(o_pc_value, 15'h7fff);
        cmp({o_stack_pop, o_pc_load, o_w}, 10'h3a5);
        rd(4'h4, 8'hff);
        wr(4'h2, 0);
        iss(14'h0009, 0, 15'h0100, 0);
        cmp(o_pc_value, 15'h0100);
        cmp({o_global_irq_enable, o_busy, o_carry}, 3'h7);
        cmp({o_stack_pop, o_pc_load}, 2'h3);
        rd(4'h2, 8'h80);
        iss(14'h0001, 0, 0, 0);
        cmp(o_soft_reset, 1);
        rd(4'h3, 0);
        rd(4'hf, 0);
        rd(4'h1, 8'h01);
        rd(4'h5, 8'h00);
        wr(4'h0, 8'h5a);
        rd(4'h0, 8'h5a);
        wr(4'h3, 8'h04);
        rd(4'h3, 8'h04);
        @(posedge i_clk);
        #1 cmp(o_rdata, 8'h00);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
